// file: core/pll_function_latch_control.sv
// serial word decode, power-down and fastlock control of the synthesizer
`timescale 1ns/1ps
`include "pll_ctrl_defines.svh"

module pll_function_latch_control
    import pll_ctrl_pkg::*;
#(
    parameter logic [`TIMER_W-1:0] TIMEOUT_STEP = `TIMEOUT_STEP
) (
    // system
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // three-wire serial link
    input  wire logic        serialClk,
    input  wire logic        serialData,
    input  wire logic        latchEnable,
    // chip enable pin
    input  wire logic        chipEnable,
    // phase detector events
    input  wire logic        cpEvent,
    input  wire logic        pfdTick,
    // monitor sources
    input  wire logic [7:0]  monitorSources,
    // counter control
    output logic             counterReset,
    output logic             refLoad,
    output logic [21:0]      refData,
    output logic             fbLoad,
    output logic [21:0]      fbData,
    output logic [1:0]       prescalerSel,
    // power-down
    output logic             powerDown,
    output logic             clockDetectReset,
    // charge pump
    output logic             cpHighZ,
    output logic [2:0]       currentCode,
    output logic             fastlockGain,
    output logic             pdPolarity,
    // monitor pin
    output logic             monitorOut
);

    // ==========================================================
    // link domain: shift register
    // ==========================================================
    link_state_t link;
    link_state_t next_link;

    always_comb begin
        next_link = link;
        // never gated by power-down
        next_link.shiftReg = {link.shiftReg[`WORD_W-2:0], serialData};
    end

    always_ff @(posedge serialClk or negedge reset_n) begin
        if (!reset_n) begin
            link <= '0;
        end else begin
            link <= next_link;
        end
    end

    // ==========================================================
    // core domain helpers
    // ==========================================================
    core_state_t s;
    core_state_t next_s;

    function automatic logic [`TIMER_W-1:0] timeoutLoad(
        input logic [3:0] code
    );
        logic [2*`TIMER_W-1:0] prod;
        prod = ({{(`TIMER_W-4){1'b0}}, code} + `TIMER_W'(1)) * TIMEOUT_STEP;
        timeoutLoad = prod[`TIMER_W-1:0] - `TIMER_W'(1);
    endfunction

    logic               latchRise;
    logic [`WORD_W-1:0] word;
    logic [1:0]         dest;
    logic               anyPd;
    logic               flEnable;
    logic               flMode2;
    logic               timerRun;
    logic               pdHeld;

    // the link clock stands still while the latch strobe is high,
    // so the word is stable when the synchronised strobe sees it
    assign word      = link.shiftReg;
    assign dest      = word[1:0];
    assign latchRise = s.leSync[1] & s.leSync[2] & ~s.leLevel;
    assign flEnable  = s.func[`BIT_FL_EN];
    assign flMode2   = flEnable & s.func[`BIT_FL_MODE];
    assign timerRun  = flMode2 & s.gain & ~pdHeld;

    // raw pin too, so the disable does not wait for the synchroniser;
    // state only sees the synchronised level, never the raw pin
    assign pdHeld = ~s.ceLevel | (s.pd == PD_DOWN);
    assign anyPd = ~chipEnable | pdHeld;

    // ==========================================================
    // core domain next state
    // ==========================================================
    always_comb begin
        next_s = s;
        next_s.leSync = {s.leSync[1:0], latchEnable};
        next_s.ceSync = {s.ceSync[1:0], chipEnable};
        next_s.resetPulse = 1'b0;
        next_s.refLoad = 1'b0;
        next_s.fbLoad = 1'b0;

        if (s.leSync[1] == s.leSync[2]) begin
            next_s.leLevel = s.leSync[2];
        end
        if (s.ceSync[1] == s.ceSync[2]) begin
            next_s.ceLevel = s.ceSync[2];
        end

        // fastlock timeout, counted in phase detector cycles
        if (!timerRun) begin
            next_s.timer = timeoutLoad(s.func[`TO_MSB:`TO_LSB]);
        end else if (pfdTick) begin
            if (s.timer == '0) begin
                next_s.gain = 1'b0;
            end else begin
                next_s.timer = s.timer - `TIMER_W'(1);
            end
        end

        // synchronous power-down waits for a charge pump event
        if (s.pd == PD_WAIT && cpEvent) begin
            next_s.pd = PD_DOWN;
        end

        if (latchRise) begin
            unique case (dest)
                `DEST_REF: begin
                    next_s.refData = word[`WORD_W-1:2];
                    next_s.refLoad = 1'b1;
                end
                `DEST_FB: begin
                    next_s.fbData = word[`WORD_W-1:2];
                    next_s.fbLoad = 1'b1;
                    // a new set wins over a same-cycle timeout
                    next_s.gain = word[`BIT_FL_GAIN];
                    if (s.armFb) begin
                        next_s.resetPulse = 1'b1;
                        next_s.armFb = 1'b0;
                    end
                end
                `DEST_FUNC, `DEST_INIT: begin
                    next_s.func = word;
                    if (!word[`BIT_PD_REQ]) begin
                        next_s.pd = PD_RUN;
                    end else if (!word[`BIT_PD_SYNC]) begin
                        next_s.pd = PD_DOWN;
                    end else if (dest == `DEST_INIT) begin
                        // the internal pulse is the trigger
                        next_s.pd = PD_DOWN;
                    end else if (next_s.pd != PD_DOWN) begin
                        next_s.pd = PD_WAIT;
                    end
                    if (dest == `DEST_INIT) begin
                        next_s.resetPulse = 1'b1;
                        next_s.armFb = 1'b1;
                    end
                end
            endcase
        end

        next_s.monitor =
            monitorSources[next_s.func[`MON_MSB:`MON_LSB]];
        // code one when static, code two during fastlock
        next_s.current = (next_s.func[`BIT_FL_EN] && next_s.gain) ?
            next_s.func[`CUR2_MSB:`CUR2_LSB] :
            next_s.func[`CUR1_MSB:`CUR1_LSB];
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '{
                leSync:     3'h0,
                leLevel:    1'b0,
                ceSync:     3'h0,
                ceLevel:    1'b0,
                func:       `FUNC_RESET,
                refData:    22'h000000,
                fbData:     22'h000000,
                refLoad:    1'b0,
                fbLoad:     1'b0,
                gain:       1'b0,
                armFb:      1'b0,
                resetPulse: 1'b0,
                pd:         PD_RUN,
                timer:      `TIMER_W'h0,
                monitor:    1'b0,
                current:    3'h0
            };
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    // one reset line for both dividers keeps them released on
    // the same edge, so they restart in close alignment
    assign counterReset = s.func[`BIT_CNT_RST] | s.resetPulse
        | anyPd;
    assign cpHighZ = s.func[`BIT_CP_TRI] | counterReset;
    assign powerDown = anyPd;
    assign clockDetectReset = anyPd;
    assign refLoad = s.refLoad;
    assign refData = s.refData;
    assign fbLoad = s.fbLoad;
    assign fbData = s.fbData;
    assign prescalerSel = s.func[`PRE_MSB:`PRE_LSB];
    assign pdPolarity = s.func[`BIT_PD_POL];
    assign currentCode = s.current;
    assign fastlockGain = s.gain;
    assign monitorOut = s.monitor;

    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    sequence initLoad;
        latchRise && dest == `DEST_INIT;
    endsequence

    sequence firstFbLoad;
        latchRise && dest == `DEST_FB && s.armFb;
    endsequence

    sequence syncRequest;
        latchRise && dest == `DEST_FUNC && word[`BIT_PD_REQ]
            && word[`BIT_PD_SYNC] && s.pd == PD_RUN;
    endsequence

    sequence pulseOnce;
        s.resetPulse && counterReset ##1 !s.resetPulse;
    endsequence

    a_init_pulse: assert property (initLoad |=> pulseOnce)
        else $error("init load gave no reset pulse");

    a_fb_rearm: assert property (firstFbLoad |=> pulseOnce ##0 !s.armFb)
        else $error("first feedback load gave no reset pulse");

    a_fb_quiet: assert property (latchRise && dest == `DEST_FB
        && !s.armFb |=> !s.resetPulse)
        else $error("later feedback load pulsed reset");

    a_counter_hold: assert property (s.func[`BIT_CNT_RST]
        |-> counterReset && cpHighZ)
        else $error("counter reset bit not holding counters");

    a_ce_disable: assert property (!chipEnable |-> powerDown)
        else $error("chip enable low but not powered down");

    a_async_pd: assert property (latchRise && dest == `DEST_FUNC
        && word[`BIT_PD_REQ] && !word[`BIT_PD_SYNC] |=> powerDown)
        else $error("asynchronous power-down late");

    a_sync_wait: assert property (syncRequest ##1 !cpEvent
        && !latchRise |=> !(s.pd == PD_DOWN) ##0 s.pd == PD_WAIT)
        else $error("synchronous power-down did not wait");

    a_sync_event: assert property (s.pd == PD_WAIT && cpEvent
        && !latchRise |=> powerDown)
        else $error("charge event did not power down");

    a_pd_effects: assert property (powerDown |-> cpHighZ
        && counterReset && clockDetectReset)
        else $error("power-down effects missing");

    a_monitor_sel: assert property (1'b1 |=> monitorOut ==
        $past(monitorSources[next_s.func[`MON_MSB:`MON_LSB]]))
        else $error("monitor output not following select");

    a_current_pick: assert property (1'b1 |-> currentCode ==
        ((flEnable && s.gain) ? s.func[`CUR2_MSB:`CUR2_LSB]
        : s.func[`CUR1_MSB:`CUR1_LSB]))
        else $error("charge pump current code wrong");

    a_timeout_end: assert property (timerRun && pfdTick
        && s.timer == '0 && !latchRise |=> !s.gain)
        else $error("fastlock timeout did not clear gain");

    a_timer_hold: assert property (!flMode2 |=>
        s.timer == timeoutLoad($past(s.func[`TO_MSB:`TO_LSB])))
        else $error("timeout counter ran outside mode 2");

    a_tristate: assert property (s.func[`BIT_CP_TRI] |-> cpHighZ)
        else $error("three-state bit ignored");

    // ==========================================================
    // load, power-down and fastlock checks
    // ==========================================================
    sequence settingsLoad;
        latchRise && dest[1];
    endsequence

    a_ref_load: assert property (latchRise && dest == `DEST_REF
        |=> refLoad && refData == $past(word[`WORD_W-1:2]))
        else $error("reference word not passed on");

    a_fb_load: assert property (latchRise && dest == `DEST_FB
        |=> fbLoad && fbData == $past(word[`WORD_W-1:2])
        && fastlockGain == $past(word[`BIT_FL_GAIN]))
        else $error("feedback word not passed on");

    a_func_load: assert property (settingsLoad |=> s.func == $past(word))
        else $error("settings word not latched");

    a_pd_release: assert property (settingsLoad ##0 !word[`BIT_PD_REQ]
        |=> s.pd == PD_RUN)
        else $error("cleared request left device powered down");

    a_init_sync: assert property (latchRise && dest == `DEST_INIT
        && word[`BIT_PD_REQ] && word[`BIT_PD_SYNC] |=> s.pd == PD_DOWN)
        else $error("init pulse did not start power-down");

    a_pd_live: assert property (latchRise && dest == `DEST_REF
        && powerDown |=> refLoad)
        else $error("word dropped during power-down");

    a_pulse_single: assert property (s.resetPulse |=> !s.resetPulse)
        else $error("internal reset pulse too long");

    a_mode1_hold: assert property (flEnable && !flMode2 && s.gain
        && !latchRise |=> s.gain)
        else $error("mode 1 gain cleared without a write");

    a_timer_step: assert property (timerRun && pfdTick
        && s.timer != '0 |=> s.timer == $past(s.timer) - `TIMER_W'(1))
        else $error("timeout counter step wrong");

    a_pd_reload: assert property (pdHeld |=>
        s.timer == timeoutLoad($past(s.func[`TO_MSB:`TO_LSB])))
        else $error("timeout counter not held at load during power-down");

endmodule // pll_function_latch_control

// file: core/pll_ctrl_defines.svh
// bit positions, destination codes and reset values of the control word
`ifndef PLL_CTRL_DEFINES_SVH
`define PLL_CTRL_DEFINES_SVH

`define WORD_W        24
`define TIMER_W       16

// destination codes in the two lowest bits
`define DEST_REF      2'h0
`define DEST_FB       2'h1
`define DEST_FUNC     2'h2
`define DEST_INIT     2'h3

// function and initialization settings layout
`define BIT_CNT_RST   2
`define BIT_PD_REQ    3
`define MON_LSB       4
`define MON_MSB       6
`define BIT_PD_POL    7
`define BIT_CP_TRI    8
`define BIT_FL_EN     9
`define BIT_FL_MODE   10
`define TO_LSB        11
`define TO_MSB        14
`define CUR1_LSB      15
`define CUR1_MSB      17
`define CUR2_LSB      18
`define CUR2_MSB      20
`define BIT_PD_SYNC   21
`define PRE_LSB       22
`define PRE_MSB       23

// feedback counter word
`define BIT_FL_GAIN   21

// reset value and default timeout step
`define FUNC_RESET    24'h000000
`define TIMEOUT_STEP  16'h0004

`endif

// file: core/pll_ctrl_pkg.sv
// types shared by the function latch control block
package pll_ctrl_pkg;
    `include "pll_ctrl_defines.svh"

    typedef enum logic [1:0] {
        PD_RUN,
        PD_WAIT,
        PD_DOWN
    } pd_state_t;

    typedef struct packed {
        logic [`WORD_W-1:0] shiftReg;
    } link_state_t;

    typedef struct packed {
        logic [2:0]         leSync;
        logic               leLevel;
        logic [2:0]         ceSync;
        logic               ceLevel;
        logic [`WORD_W-1:0] func;
        logic [`WORD_W-3:0] refData;
        logic [`WORD_W-3:0] fbData;
        logic               refLoad;
        logic               fbLoad;
        logic               gain;
        logic               armFb;
        logic               resetPulse;
        pd_state_t          pd;
        logic [`TIMER_W-1:0] timer;
        logic               monitor;
        logic [2:0]         current;
    } core_state_t;
endpackage

// file: bench/host_serial_model.sv
// host side model that shifts control words over the three-wire link
`timescale 1ns/1ps

module host_serial_model (
    // core clock for strobe timing
    input  wire logic mclk,
    // three-wire link
    output logic      serialClk,
    output logic      serialData,
    output logic      latchEnable
);
    initial begin
        serialClk   = 1'b0;
        serialData  = 1'b1;
        latchEnable = 1'b0;
    end

    // ==========================================
    // word transfer
    // link clock runs only inside a frame, 15 ns period, msb first
    task automatic send(input logic [23:0] word);
        #3.3;
        for (int i = 23; i >= 0; i--) begin
            serialData = word[i];
            #7.5 serialClk = 1'b1;
            #7.5 serialClk = 1'b0;
        end
        // released line shows no stale bit
        serialData = ~word[0];
        @(posedge mclk);
        latchEnable <= 1'b1;
        repeat (6) @(posedge mclk);
        latchEnable <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask
endmodule // host_serial_model

// file: bench/pll_function_latch_control_test.sv
// self-checking bench of the function latch control block
`timescale 1ns/1ps
`include "pll_ctrl_defines.svh"
`define CHK(nm, exp, got) begin nChecks++; if ((got) !== (exp)) begin nFail++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end

module pll_function_latch_control_test;
    import pll_ctrl_pkg::*;
    localparam logic [15:0] STEP = 16'h0002;
    localparam logic [23:0] FN   = 24'h000002;
    localparam logic [23:0] INIT = 24'h000003;
    // place of the A count field in the feedback word
    localparam logic [23:0] A_FIELD = 24'h0000fc;
    logic        mclk, reset_n, chipEnable, cpEvent, pfdTick;
    logic        serialClk, serialData, latchEnable;
    logic        counterReset, refLoad, fbLoad, powerDown, clockDetectReset;
    logic        cpHighZ, fastlockGain, pdPolarity, monitorOut;
    logic [7:0]  monitorSources;
    logic [21:0] refData, fbData;
    logic [1:0]  prescalerSel;
    logic [2:0]  currentCode;
    logic [23:0] expQ[$];
    logic [23:0] note;
    int          nFail, nChecks, crCount, cycles;

    pll_function_latch_control #(.TIMEOUT_STEP(STEP)) DUT (
        .mclk(mclk), .reset_n(reset_n), .serialClk(serialClk), .serialData(serialData),
        .latchEnable(latchEnable), .chipEnable(chipEnable), .cpEvent(cpEvent),
        .pfdTick(pfdTick), .monitorSources(monitorSources), .counterReset(counterReset),
        .refLoad(refLoad), .refData(refData), .fbLoad(fbLoad), .fbData(fbData),
        .prescalerSel(prescalerSel), .powerDown(powerDown),
        .clockDetectReset(clockDetectReset), .cpHighZ(cpHighZ), .currentCode(currentCode),
        .fastlockGain(fastlockGain), .pdPolarity(pdPolarity), .monitorOut(monitorOut));

    host_serial_model host (
        .mclk(mclk), .serialClk(serialClk), .serialData(serialData),
        .latchEnable(latchEnable));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ==========================================
    // helpers
    function automatic logic [23:0] bitAt(input int p);
        return 24'h1 << p;
    endfunction

    // A count kept at zero, so B can never fall below it
    function automatic logic [23:0] fbWord(input logic gain);
        logic [23:0] w;
        w = {22'($urandom()), `DEST_FB} & ~A_FIELD;
        w[`BIT_FL_GAIN] = gain;
        return w;
    endfunction

    task automatic closeOut();
        $display("checks %0d mismatches %0d", nChecks, nFail);
        if (nFail == 0 && nChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // counter words are noted so the watcher can match each load pulse
    task automatic wr(input logic [23:0] w);
        if (w[1:0] < 2'h2)
            expQ.push_back(w);
        host.send(w);
        repeat (2) @(posedge mclk);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            pfdTick <= 1'b1;
            @(posedge mclk);
            pfdTick <= 1'b0;
            @(posedge mclk);
        end
        repeat (2) @(posedge mclk);
    endtask

    // ==========================================
    // watcher: load pulses, reset pulses, hang guard
    always @(posedge mclk) begin
        cycles++;
        if (counterReset === 1'b1)
            crCount++;
        if (refLoad === 1'b1 || fbLoad === 1'b1) begin
            note = (expQ.size() > 0) ? expQ.pop_front() : 24'hffffff;
            `CHK("loadDest", note[1:0], {1'b0, fbLoad})
            `CHK("loadData", note[23:2], (fbLoad ? fbData : refData))
        end
        if (cycles == 20000) begin
            nFail++;
            closeOut();
        end
    end

    // ==========================================
    // main sequence
    initial begin
        logic [23:0] gw, cur;
        logic [2:0]  c1, c2;
        logic [3:0]  to;
        int          base;
        reset_n = 1'b0;
        chipEnable = 1'b1;
        cpEvent = 1'b0;
        pfdTick = 1'b0;
        monitorSources = 8'h00;
        nFail = 0;
        nChecks = 0;
        crCount = 0;
        cycles = 0;
        void'($urandom(32'hd949f9a1));
        repeat (3) @(posedge mclk);
        `CHK("cpHighZRst", 1'b1, cpHighZ)
        reset_n <= 1'b1;
        repeat (5) @(posedge mclk);
        `CHK("powerDownRun", 1'b0, powerDown)
        wr({22'($urandom()), `DEST_REF});
        base = crCount;
        // host keeps prescaler output in range
        wr(INIT | bitAt(`BIT_PD_POL) | (24'h3 << `PRE_LSB));
        `CHK("initPulse", 1, crCount - base)
        `CHK("prescaler", 2'h3, prescalerSel)
        `CHK("polarity", 1'b1, pdPolarity)
        wr(fbWord(1'b0));
        `CHK("fbPulse", 2, crCount - base)
        wr(fbWord(1'b0));
        `CHK("fbNoPulse", 2, crCount - base)
        wr(FN | bitAt(`BIT_CNT_RST));
        `CHK("cntRst", 1'b1, counterReset)
        wr(FN | bitAt(`BIT_CP_TRI));
        `CHK("cntRun", 1'b0, counterReset)
        `CHK("triOn", 1'b1, cpHighZ)
        wr(FN);
        `CHK("triOff", 1'b0, cpHighZ)
        `CHK("polarity", 1'b0, pdPolarity)
        chipEnable <= 1'b0;
        #1;
        `CHK("cePd", 1'b1, powerDown)
        `CHK("ceDetect", 1'b1, clockDetectReset)
        @(posedge mclk);
        chipEnable <= 1'b1;
        repeat (5) @(posedge mclk);
        wr(FN | bitAt(`BIT_PD_REQ));
        `CHK("asyncPd", 1'b1, powerDown)
        wr({22'($urandom()), `DEST_REF});
        wr(FN);
        `CHK("pdOff", 1'b0, powerDown)
        wr(FN | bitAt(`BIT_PD_REQ) | bitAt(`BIT_PD_SYNC));
        `CHK("syncWait", 1'b0, powerDown)
        cpEvent <= 1'b1;
        @(posedge mclk);
        cpEvent <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK("syncPd", 1'b1, powerDown)
        wr(FN);
        wr(INIT | bitAt(`BIT_PD_REQ) | bitAt(`BIT_PD_SYNC));
        `CHK("initSyncPd", 1'b1, powerDown)
        wr(FN);
        for (int s = 0; s < 8; s++) begin
            monitorSources <= 8'($urandom());
            wr(FN | (24'(s) << `MON_LSB));
            `CHK("monitor", monitorSources[s], monitorOut)
        end
        c1 = 3'($urandom());
        c2 = ~c1;
        cur = (24'(c1) << `CUR1_LSB) | (24'(c2) << `CUR2_LSB);
        gw = fbWord(1'b1);
        wr(FN | cur);
        wr(gw);
        `CHK("flOff", c1, currentCode)
        wr(FN | cur | bitAt(`BIT_FL_EN));
        `CHK("mode1", c2, currentCode)
        tick(40);
        `CHK("mode1Hold", c2, currentCode)
        wr(gw & ~bitAt(`BIT_FL_GAIN));
        `CHK("static", c1, currentCode)
        to = 4'($urandom() & 3);
        wr(FN | cur | bitAt(`BIT_FL_EN) | bitAt(`BIT_FL_MODE) | (24'(to) << `TO_LSB));
        wr(gw);
        `CHK("mode2", c2, currentCode)
        tick((int'(to) + 1) * int'(STEP) - 1);
        `CHK("timerRun", 1'b1, fastlockGain)
        tick(1);
        `CHK("timeout", c1, currentCode)
        `CHK("gainClear", 1'b0, fastlockGain)
        `CHK("queueEmpty", 0, expQ.size())
        closeOut();
    end
endmodule // pll_function_latch_control_test
